// ===== src/secure_remote_command_gate.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module secure_remote_command_gate
	import cmd_gate_pkg::*;
#(
	parameter int RATE_W = 16 // width of the pending parameter
) (
	input wire logic clk, // 20 MHz clock
	input wire logic reset, // synchronous, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic tx_valid, // air command pulse
	output logic [7:0] tx_fid, // air command frame id
	output logic tx_secure, // air command secure flag
	output logic tx_set, // air command is a set
	output logic tx_apply, // air command apply option
	output logic [RATE_W-1:0] tx_value, // air command parameter
	input wire logic rx_resp_valid, // air response arrived
	input wire logic [7:0] rx_resp_fid, // its frame id
	input wire logic [7:0] rx_resp_status, // its status
	input wire logic [RATE_W-1:0] rx_resp_value, // its queried value
	input wire logic tx_unreachable, // destination not reached
	input wire logic rx_cmd_valid, // air command arrived
	input wire logic [7:0] rx_cmd_fid, // its frame id
	input wire logic rx_cmd_secure, // its secure flag
	input wire logic rx_cmd_set, // set rather than query
	input wire logic rx_cmd_apply, // apply option bit
	input wire logic [RATE_W-1:0] rx_cmd_value, // its parameter
	output logic reply_valid, // air reply pulse
	output logic [7:0] reply_fid, // air reply frame id
	output logic [7:0] reply_status, // air reply status
	output logic [RATE_W-1:0] reply_value, // air reply value
	output logic [RATE_W-1:0] serial_rate_param // applied rate
);
	if (RATE_W < 1 || RATE_W > 16) begin : g_bad_width
		$error("RATE_W must be 1..16");
	end

	logic [31:0] remote_cmd_password_q;
	logic [31:0] network_encryption_key_q;
	logic enc_on_q, saved_q;
	logic [RATE_W-1:0] pend_q, saved_rate_q, rate_q;
	logic [31:0] req_q, req_pwd_q;
	logic resp_full_q;
	logic [7:0] resp_fid_q, resp_status_q;
	logic [RATE_W-1:0] resp_value_q;
	logic [7:0] rejected_q;
	logic aw_hold_q, w_hold_q, w_full_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;

	// write channel: address and data taken in either order
	wire aw_have = aw_hold_q || s_axi_awvalid;
	wire w_have = w_hold_q || s_axi_wvalid;
	wire [7:0] wr_addr = aw_hold_q ? aw_q : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_q ? w_q : s_axi_wdata;
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;
	// a partial word is held too, so a late address cannot stall the channel
	wire wr_full = wr_fire && (w_hold_q ? w_full_q : s_axi_wstrb == 4'hF);
	wire wr_ctrl = wr_full && wr_addr == OFF_CTRL;
	wire wr_pwd = wr_full && wr_addr == OFF_PWD_WRITE;
	wire wr_key = wr_full && wr_addr == OFF_KEY;
	wire wr_req = wr_full && wr_addr == OFF_REQ;
	wire wr_rpwd = wr_full && wr_addr == OFF_REQ_PWD;
	wire wr_pend = wr_full && wr_addr == OFF_PEND_RATE;
	wire wr_resp = wr_full && wr_addr == OFF_RESP;
	wire wr_known = wr_ctrl || wr_pwd || wr_key || wr_req || wr_rpwd || wr_pend || wr_resp;
	wire do_restore = wr_ctrl && wr_data[CTRL_RESTORE_BIT];
	wire do_apply = wr_ctrl && wr_data[CTRL_APPLY_BIT];
	wire do_save = wr_ctrl && wr_data[CTRL_SAVE_BIT];
	wire do_swreset = wr_ctrl && wr_data[CTRL_SWRESET_BIT];

	wire node_secured = remote_cmd_password_q != PWD_DEFAULT;
	// the password register takes current then new in one 32-bit word
	wire pwd_ok_write = wr_data[15:0] == remote_cmd_password_q[15:0];

	// send-side admission
	wire [7:0] chk_code;
	wire chk_allow;
	wire req_secure = wr_data[REQ_SECURE_BIT];
	// the zero default stands for ASCII zero in the password field
	wire [31:0] req_pwd_eff = (req_pwd_q == 32'h0000_0000) ? PWD_DEFAULT : req_pwd_q;
	send_check u_check (
		.secure_req(req_secure),
		.bcast_req(wr_data[REQ_BCAST_BIT]),
		.enc_on(enc_on_q),
		.node_secured(node_secured),
		.pwd_match(req_pwd_eff == remote_cmd_password_q),
		.code(chk_code),
		.allow(chk_allow)
	);
	wire req_fid_nz = wr_data[REQ_FID_LSB +: 8] != 8'h00;
	wire loc_refuse = wr_req && !chk_allow && req_fid_nz;

	// receive side: secured node withholds unsecured commands
	wire rx_reject = rx_cmd_valid && node_secured && !rx_cmd_secure;
	wire rx_exec = rx_cmd_valid && !rx_reject;
	wire rx_set = rx_exec && rx_cmd_set;

	// response holding register: air response, or a local refusal
	wire resp_from_air = rx_resp_valid && rx_resp_fid != 8'h00 && !tx_unreachable;
	wire resp_load = resp_from_air || loc_refuse;
	wire resp_clear = wr_resp && !resp_load; // set wins over clear

	always_ff @(posedge clk) begin
		if (reset || do_restore) begin
			remote_cmd_password_q <= PWD_DEFAULT;
			network_encryption_key_q <= KEY_DEFAULT;
		end else begin
			if (wr_pwd && pwd_ok_write)
				remote_cmd_password_q <= {16'h0000, wr_data[31:16]};
			if (wr_key)
				network_encryption_key_q <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			enc_on_q <= 1'b0;
			req_q <= 32'h0000_0000;
			req_pwd_q <= 32'h0000_0000;
		end else begin
			if (wr_ctrl)
				enc_on_q <= wr_data[CTRL_ENC_BIT];
			if (wr_req)
				req_q <= wr_data;
			if (wr_rpwd)
				req_pwd_q <= wr_data;
		end
	end

	// pending, saved and applied parameter
	always_ff @(posedge clk) begin
		if (reset) begin
			pend_q <= RATE_DEFAULT[RATE_W-1:0];
			saved_rate_q <= RATE_DEFAULT[RATE_W-1:0];
			saved_q <= 1'b0;
			rate_q <= RATE_DEFAULT[RATE_W-1:0];
		end else begin
			if (rx_set)
				pend_q <= rx_cmd_value;
			else if (wr_pend)
				pend_q <= wr_data[RATE_W-1:0];
			if (do_save) begin
				saved_rate_q <= pend_q;
				saved_q <= 1'b1;
			end
			if (do_apply || (rx_set && rx_cmd_apply))
				rate_q <= (rx_set && rx_cmd_apply) ? rx_cmd_value : pend_q;
			else if (do_swreset && saved_q)
				rate_q <= saved_rate_q;
		end
	end

	// over-the-air transmit, never carrying the password
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_fid <= 8'h00;
			tx_secure <= 1'b0;
			tx_set <= 1'b0;
			tx_apply <= 1'b0;
			tx_value <= '0;
		end else begin
			tx_valid <= wr_req && chk_allow;
			if (wr_req && chk_allow) begin
				tx_fid <= wr_data[REQ_FID_LSB +: 8];
				tx_secure <= req_secure;
				tx_set <= wr_data[REQ_SET_BIT];
				tx_apply <= wr_data[REQ_APPLY_BIT];
				tx_value <= wr_data[REQ_VAL_LSB +: RATE_W];
			end
		end
	end

	// reply to peer commands
	always_ff @(posedge clk) begin
		if (reset) begin
			reply_valid <= 1'b0;
			reply_fid <= 8'h00;
			reply_status <= ST_OK;
			reply_value <= '0;
			rejected_q <= 8'h00;
		end else begin
			reply_valid <= rx_cmd_valid && rx_cmd_fid != 8'h00;
			if (rx_cmd_valid) begin
				reply_fid <= rx_cmd_fid;
				reply_status <= rx_reject ? ST_BAD_FRAME : ST_OK;
				reply_value <= rx_reject ? '0 : (rx_cmd_set ? rx_cmd_value : pend_q);
			end
			if (rx_reject)
				rejected_q <= rejected_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			resp_full_q <= 1'b0;
			resp_fid_q <= 8'h00;
			resp_status_q <= ST_OK;
			resp_value_q <= '0;
		end else if (resp_load) begin
			resp_full_q <= 1'b1;
			resp_fid_q <= resp_from_air ? rx_resp_fid : wr_data[REQ_FID_LSB +: 8];
			resp_status_q <= resp_from_air ? rx_resp_status : chk_code;
			resp_value_q <= resp_from_air ? rx_resp_value : '0;
		end else if (resp_clear) begin
			resp_full_q <= 1'b0;
		end
	end

	assign serial_rate_param = rate_q;

	// axi write channel
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			w_full_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= !wr_fire;
				aw_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= !wr_fire;
				w_full_q <= s_axi_wstrb == 4'hF;
				w_q <= s_axi_wdata;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

	// axi read channel; password and key read as zero
	wire [7:0] rd_status = {4'h0, saved_q, resp_full_q, node_secured, enc_on_q};
	wire rd_known = s_axi_araddr <= OFF_COUNT && s_axi_araddr[1:0] == 2'b00;
	wire [31:0] rd_mux =
		s_axi_araddr == OFF_CTRL ? {31'h0000_0000, enc_on_q} :
		s_axi_araddr == OFF_STATUS ? {24'h00_0000, rd_status} :
		s_axi_araddr == OFF_PEND_RATE ? {{(32-RATE_W){1'b0}}, pend_q} :
		s_axi_araddr == OFF_ACT_RATE ? {{(32-RATE_W){1'b0}}, rate_q} :
		s_axi_araddr == OFF_REQ ? req_q :
		s_axi_araddr == OFF_RESP ? 32'({resp_value_q, resp_status_q, resp_fid_q}) :
		s_axi_araddr == OFF_COUNT ? {24'h00_0000, rejected_q} : 32'h0000_0000;
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	sequence zero_fid_cmd;
		rx_cmd_valid && rx_cmd_fid == 8'h00;
	endsequence
	a_zero_fid_quiet: assert property (@(posedge clk) disable iff (reset) zero_fid_cmd |=> !reply_valid)
		else $error("reply sent for zero frame id");
	a_secure_rx_reject: assert property (@(posedge clk) disable iff (reset)
		rx_cmd_valid && rx_cmd_fid != 8'h00 && node_secured && !rx_cmd_secure
		|=> reply_valid && reply_status == ST_BAD_FRAME)
		else $error("unsecured command not rejected");
	a_plain_blocked: assert property (@(posedge clk) disable iff (reset)
		wr_req && !req_secure && node_secured |=> !tx_valid)
		else $error("plain request sent from secured node");
	a_enc_needed: assert property (@(posedge clk) disable iff (reset) tx_valid && tx_secure |-> $past(enc_on_q))
		else $error("secure request sent without encryption");
	a_no_bcast: assert property (@(posedge clk) disable iff (reset)
		wr_req && wr_data[REQ_BCAST_BIT] |=> !tx_valid)
		else $error("broadcast remote command sent");
	a_restore_pwd: assert property (@(posedge clk) disable iff (reset)
		do_restore |=> !node_secured && network_encryption_key_q == KEY_DEFAULT)
		else $error("restore left password or key");
	a_pend_hold: assert property (@(posedge clk) disable iff (reset)
		rx_set && !rx_cmd_apply && !do_apply && !do_swreset |=> $stable(serial_rate_param))
		else $error("pending change took effect early");
	a_air_echo: assert property (@(posedge clk) disable iff (reset)
		resp_from_air |=> resp_full_q && resp_fid_q == $past(rx_resp_fid))
		else $error("response frame id not echoed");
	a_pwd_hidden: assert property (@(posedge clk) disable iff (reset)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PWD_WRITE |=> s_axi_rdata == 32'h0000_0000)
		else $error("password read back");
	a_pwd_guarded: assert property (@(posedge clk) disable iff (reset)
		wr_pwd && !pwd_ok_write |=> $stable(remote_cmd_password_q))
		else $error("password changed without current value");
endmodule : secure_remote_command_gate

// ===== src/cmd_gate_pkg.sv
package cmd_gate_pkg;
	// register byte offsets, chosen here
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PWD_WRITE = 8'h08;
	localparam logic [7:0] OFF_KEY = 8'h0C;
	localparam logic [7:0] OFF_PEND_RATE = 8'h10;
	localparam logic [7:0] OFF_ACT_RATE = 8'h14;
	localparam logic [7:0] OFF_REQ = 8'h18;
	localparam logic [7:0] OFF_REQ_PWD = 8'h1C;
	localparam logic [7:0] OFF_RESP = 8'h20;
	localparam logic [7:0] OFF_COUNT = 8'h24;
	// control register bit positions
	localparam int CTRL_ENC_BIT = 0;
	localparam int CTRL_RESTORE_BIT = 1;
	localparam int CTRL_APPLY_BIT = 2;
	localparam int CTRL_SAVE_BIT = 3;
	localparam int CTRL_SWRESET_BIT = 4;
	// request register fields
	localparam int REQ_FID_LSB = 0;
	localparam int REQ_SECURE_BIT = 8;
	localparam int REQ_BCAST_BIT = 9;
	localparam int REQ_APPLY_BIT = 10;
	localparam int REQ_SET_BIT = 11;
	localparam int REQ_VAL_LSB = 16;
	// reset values
	localparam logic [31:0] PWD_DEFAULT = 32'h0000_0030;
	localparam logic [31:0] KEY_DEFAULT = 32'h0000_0000;
	localparam logic [15:0] RATE_DEFAULT = 16'h0000;
	// status codes
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_ERROR = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_PARAM = 8'h03;
	localparam logic [7:0] ST_NO_RESP = 8'h04;
	localparam logic [7:0] ST_BAD_PWD = 8'h08;
	localparam logic [7:0] ST_BAD_FRAME = 8'h09;
	localparam logic [7:0] ST_NO_ENC = 8'h0A;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cmd_gate_pkg

// ===== src/send_check.sv
`timescale 1ns/1ps
module send_check
	import cmd_gate_pkg::*;
(
	input wire logic secure_req, // request carries a password
	input wire logic bcast_req, // destination is broadcast
	input wire logic enc_on, // encryption enabled
	input wire logic node_secured, // local password not default
	input wire logic pwd_match, // supplied password equals stored
	output logic [7:0] code, // send-side verdict
	output logic allow // request may go on the air
);
	wire enc_fail = secure_req && !enc_on;
	wire type_fail = !secure_req && node_secured;
	wire pwd_fail = secure_req && !pwd_match;
	assign code = enc_fail ? ST_NO_ENC :
		type_fail ? ST_BAD_FRAME :
		pwd_fail ? ST_BAD_PWD :
		bcast_req ? ST_ERROR : ST_OK;
	assign allow = (code == ST_OK);
endmodule : send_check

// ===== tb/peer_node.sv
`timescale 1ns/1ps
module peer_node
	import cmd_gate_pkg::*;
#(
	parameter int DELAY = 6, // cycles until the answer comes back
	parameter logic [15:0] QVAL = 16'h1357 // value every query returns
) (
	input wire logic clk, // module clock
	input wire logic reset, // synchronous, active high
	input wire logic tx_valid, // command leaves the gate
	input wire logic [7:0] tx_fid, // its frame id
	input wire logic unreach, // bench asks for a dead route
	output logic rx_resp_valid, // answer pulse
	output logic [7:0] rx_resp_fid, // answer frame id
	output logic [7:0] rx_resp_status, // answer status
	output logic [15:0] rx_resp_value, // answer value
	output logic tx_unreachable // route failure level
);
	logic [7:0] fid_q;
	int cnt_q;
	logic [15:0] scr_q;
	logic fire;
	assign fire = (cnt_q == 1);
	// still answers on a dead route, so the gate has a stale answer to drop
	assign tx_unreachable = unreach;
	always @(posedge clk) begin
		scr_q <= scr_q + 16'h0001;
		if (reset) begin
			cnt_q <= 0;
			scr_q <= 16'h5a3c;
		end else if (tx_valid && tx_fid != 8'h00) begin
			cnt_q <= DELAY;
			fid_q <= tx_fid;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
		rx_resp_valid <= fire && !reset;
		// idle fid and value lines take a counter that moves every cycle instead of holding the last answer
		rx_resp_fid <= fire ? fid_q : scr_q[7:0];
		rx_resp_status <= fire ? ST_OK : ~scr_q[15:8];
		rx_resp_value <= fire ? QVAL : ~scr_q;
	end
endmodule : peer_node

// ===== tb/tb_secure_remote_command_gate.sv
`timescale 1ns/1ps
module tb_secure_remote_command_gate;
	import cmd_gate_pkg::*;
	localparam logic [15:0] QVAL = 16'h1357;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, unreach = 1'b0;
	logic rx_v = 1'b0, rx_sec = 1'b0, rx_set = 1'b0, rx_apply = 1'b0, tx_sec;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_fid = 8'h00, rp_st, rp_fid;
	logic [31:0] wdata = 32'h0000_0000, rd_q, rdata;
	logic [3:0] strb = 4'hf;
	logic [15:0] rx_val = 16'h0000, tx_val, tx_value, rr_val, reply_value, rate;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_secure, tx_set, tx_apply, rr_v, unr, reply_valid;
	logic [1:0] bresp, rresp, br_q, rr_q, tx_sa;
	logic [7:0] tx_fd;
	logic [15:0] rp_val;
	logic [7:0] tx_fid, rr_fid, rr_st, reply_fid, reply_status;
	int err_total = 0, comparisons = 0, tx_n = 0, rp_n = 0, cyc = 0;

	always #25 clk = ~clk;

	secure_remote_command_gate uut (.clk(clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_valid(tx_valid), .tx_fid(tx_fid), .tx_secure(tx_secure), .tx_set(tx_set),
		.tx_apply(tx_apply), .tx_value(tx_value), .rx_resp_valid(rr_v), .rx_resp_fid(rr_fid),
		.rx_resp_status(rr_st), .rx_resp_value(rr_val), .tx_unreachable(unr), .rx_cmd_valid(rx_v),
		.rx_cmd_fid(rx_fid), .rx_cmd_secure(rx_sec), .rx_cmd_set(rx_set), .rx_cmd_apply(rx_apply),
		.rx_cmd_value(rx_val), .reply_valid(reply_valid), .reply_fid(reply_fid), .reply_status(reply_status),
		.reply_value(reply_value), .serial_rate_param(rate));

	peer_node #(.DELAY(6), .QVAL(QVAL)) peer (.clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_fid(tx_fid),
		.unreach(unreach), .rx_resp_valid(rr_v), .rx_resp_fid(rr_fid), .rx_resp_status(rr_st),
		.rx_resp_value(rr_val), .tx_unreachable(unr));

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// sampled mid-cycle so register updates at the edge have landed
	always @(negedge clk) begin
		cyc++;
		if (tx_valid === 1'b1) begin
			tx_n++;
			tx_sec = tx_secure;
			tx_val = tx_value;
			tx_fd = tx_fid;
			tx_sa = {tx_set, tx_apply};
		end
		if (reply_valid === 1'b1) begin
			rp_n++;
			rp_st = reply_status;
			rp_fid = reply_fid;
			rp_val = reply_value;
		end
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			br_q = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			rd_q = rdata;
			rr_q = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd

	task rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_q, exp);
	endtask : rc

	function automatic logic [31:0] rq(input logic [7:0] f, input logic s, input logic b);
		return {16'h00c4, 4'h0, 1'b0, 1'b0, b, s, f};
	endfunction : rq

	// er holds {status, fid} of the expected answer, zero when none may appear
	task sc(input logic [31:0] r, input logic [31:0] p, input logic et, input logic [15:0] er);
		int n;
		n = tx_n;
		wr(OFF_RESP, 32'h0000_0000);
		wr(OFF_REQ_PWD, p);
		wr(OFF_REQ, r);
		repeat (12) @(posedge clk);
		chk(32'(tx_n - n), {31'h0, et});
		if (et) begin
			chk({24'h0, tx_fd}, {24'h0, r[7:0]});
			chk({30'h0, tx_sa}, {30'h0, r[11], r[10]});
		end
		rd(OFF_STATUS);
		chk({31'h0, rd_q[2]}, {31'h0, er != 16'h0000});
		if (er != 16'h0000) begin
			rd(OFF_RESP);
			chk({16'h0000, rd_q[15:0]}, {16'h0000, er});
		end
	endtask : sc

	task rx(input logic [7:0] f, input logic s, input logic a, input logic [15:0] v);
		int n;
		n = rp_n;
		@(posedge clk);
		rx_v <= 1'b1;
		rx_fid <= f;
		rx_sec <= s;
		rx_set <= 1'b1;
		rx_apply <= a;
		rx_val <= v;
		@(posedge clk);
		rx_v <= 1'b0;
		rx_fid <= ~f;
		rx_sec <= ~s;
		rx_set <= 1'b0;
		rx_apply <= ~a;
		rx_val <= ~v;
		repeat (4) @(posedge clk);
		chk(32'(rp_n - n), {31'h0, f != 8'h00});
	endtask : rx

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rc(OFF_CTRL, 32'h0000_0000);
		rc(OFF_STATUS, 32'h0000_0000);
		wr(OFF_KEY, 32'ha5a5_0001);
		chk({30'h0, br_q}, {30'h0, RESP_OKAY});
		wr(8'h3c, 32'h0000_0000);
		chk({30'h0, br_q}, {30'h0, RESP_SLVERR});
		rc(OFF_KEY, 32'h0000_0000);
		rc(OFF_PWD_WRITE, 32'h0000_0000);
		rc(OFF_ACT_RATE, 32'h0000_0000);
		rd(8'h3c);
		chk({30'h0, rr_q}, {30'h0, RESP_SLVERR});
		$display("test reset and map done");
		sc(rq(8'h21, 1'b0, 1'b0), 32'h0, 1'b1, {ST_OK, 8'h21});
		rc(OFF_RESP, {QVAL, ST_OK, 8'h21});
		chk({31'h0, tx_sec}, 32'h0000_0000);
		sc(rq(8'h22, 1'b1, 1'b0), 32'h0, 1'b0, {ST_NO_ENC, 8'h22});
		wr(OFF_CTRL, 32'h0000_0001);
		sc(rq(8'h23, 1'b1, 1'b0) | 32'h0000_0c00, 32'h0, 1'b1, {ST_OK, 8'h23});
		chk({31'h0, tx_sec}, 32'h0000_0001);
		chk({16'h0000, tx_val}, 32'h0000_00c4);
		sc(rq(8'h24, 1'b1, 1'b0), 32'h1234, 1'b0, {ST_BAD_PWD, 8'h24});
		$display("test send while unsecured done");
		wr(OFF_PWD_WRITE, 32'h7777_1111);
		rc(OFF_STATUS, 32'h0000_0005);
		wr(OFF_PWD_WRITE, 32'h5555_0030);
		rc(OFF_STATUS, 32'h0000_0007);
		sc(rq(8'h25, 1'b0, 1'b0), 32'h0, 1'b0, {ST_BAD_FRAME, 8'h25});
		sc(rq(8'h00, 1'b0, 1'b0), 32'h0, 1'b0, 16'h0000);
		sc(rq(8'h26, 1'b1, 1'b0), 32'h5555, 1'b1, {ST_OK, 8'h26});
		sc(rq(8'h27, 1'b1, 1'b1), 32'h5555, 1'b0, {ST_ERROR, 8'h27});
		sc(rq(8'h00, 1'b1, 1'b0), 32'h5555, 1'b1, 16'h0000);
		wr(OFF_CTRL, 32'h0000_0000);
		sc(rq(8'h28, 1'b1, 1'b0), 32'h1234, 1'b0, {ST_NO_ENC, 8'h28});
		wr(OFF_CTRL, 32'h0000_0001);
		unreach <= 1'b1;
		sc(rq(8'h29, 1'b1, 1'b0), 32'h5555, 1'b1, 16'h0000);
		unreach <= 1'b0;
		$display("test send while secured done");
		rx(8'h31, 1'b0, 1'b0, 16'h00ab);
		chk({rp_st, rp_fid}, {16'h0000, ST_BAD_FRAME, 8'h31});
		rc(OFF_PEND_RATE, 32'h0000_0000);
		rc(OFF_COUNT, 32'h0000_0001);
		rx(8'h32, 1'b1, 1'b0, 16'h00ab);
		chk({rp_st, rp_fid}, {16'h0000, ST_OK, 8'h32});
		chk({16'h0000, rp_val}, 32'h0000_00ab);
		rc(OFF_PEND_RATE, 32'h0000_00ab);
		rc(OFF_ACT_RATE, 32'h0000_0000);
		rx(8'h00, 1'b1, 1'b0, 16'h00ab);
		wr(OFF_CTRL, 32'h0000_0005);
		rc(OFF_ACT_RATE, 32'h0000_00ab);
		chk({16'h0000, rate}, 32'h0000_00ab);
		rx(8'h33, 1'b1, 1'b1, 16'h00cd);
		rc(OFF_ACT_RATE, 32'h0000_00cd);
		strb <= 4'h3;
		wr(OFF_PEND_RATE, 32'h0000_1111);
		strb <= 4'hf;
		rc(OFF_PEND_RATE, 32'h0000_00cd);
		wr(OFF_PEND_RATE, 32'h0000_00ef);
		wr(OFF_CTRL, 32'h0000_0009);
		rc(OFF_ACT_RATE, 32'h0000_00cd);
		wr(OFF_CTRL, 32'h0000_0011);
		rc(OFF_ACT_RATE, 32'h0000_00ef);
		$display("test receive and apply done");
		wr(OFF_CTRL, 32'h0000_0002);
		rd(OFF_STATUS);
		chk({31'h0, rd_q[1]}, 32'h0000_0000);
		// key erasure is invisible here since the key never reads back
		sc(rq(8'h34, 1'b0, 1'b0), 32'h0, 1'b1, {ST_OK, 8'h34});
		$display("test restore defaults done");
		end_sim();
	end
endmodule : tb_secure_remote_command_gate
